// File: core/adc_serial_pkg.sv
package adc_serial_pkg;

    // Frame geometry in serial clock bits.
    localparam int DATA_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int MAX_FRAME_BITS = 32;
    localparam logic [5:0] BASE_FRAME_LEN = 6'h10;
    localparam logic [5:0] EXTRA_BYTE_LEN = 6'h08;

    // Output code limits.
    localparam logic [15:0] UNI_FULL_SCALE = 16'hffff;
    localparam logic [15:0] UNI_ZERO = 16'h0000;
    localparam logic signed [17:0] UNI_MAX_RAW = 18'sh0ffff;
    localparam logic signed [17:0] BIP_MAX_RAW = 18'sh07fff;
    localparam logic signed [17:0] BIP_MIN_RAW = -18'sh08000;
    // Extended range scales by 13107/16384, so full scale lands on cccc.
    localparam logic [14:0] EXT_SCALE_MUL = 15'h3333;
    localparam int EXT_SCALE_SHIFT = 14;

    // Status header bit positions.
    localparam int STAT_NEW_DATA_BIT = 0;
    localparam int STAT_THREE_WIRE_BIT = 7;

    // Converter clocks from a standby-mode ready low back to high.
    localparam logic [1:0] STANDBY_READY_TICKS = 2'h3;

    // Three-wire frame reset pattern.
    localparam logic [6:0] RESYNC_ONES = 7'h3f;

    // Clock cycles after reset release before the chip select strap is caught;
    // covers the three-flop synchroniser.
    localparam logic [2:0] STRAP_WAIT_CYCLES = 3'h4;

    // Conversion control modes.
    typedef enum logic [1:0] {
        MODE_SYNC = 2'h0,
        MODE_START_STOP = 2'h1,
        MODE_ONE_SHOT = 2'h2
    } control_mode_t;

endpackage

// File: core/pin_sync.sv
`timescale 1ns/10ps

// Three-flop synchroniser; the level moves only when stages two and three agree.
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic pin,
    output logic level
);

    logic stage1_reg; // Metastability catcher, read only by stage two.
    logic stage2_reg; // Second stage.
    logic stage3_reg; // Third stage.

    // The filtered level only follows when the last two stages match.
    always_ff @(posedge clk) begin
        if (reset) begin
            stage1_reg <= RESET_LEVEL;
            stage2_reg <= RESET_LEVEL;
            stage3_reg <= RESET_LEVEL;
            level <= RESET_LEVEL;
        end else begin
            stage1_reg <= pin;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            if (stage2_reg == stage3_reg) begin
                level <= stage3_reg;
            end
        end
    end

endmodule

// File: core/ready_signal.sv
`timescale 1ns/10ps

// Drives the active-low result ready level from conversion events.
module ready_signal (
    input wire logic clk,
    input wire logic reset,
    input wire logic restart,
    input wire logic result,
    input wire logic read_hit,
    input wire logic standby_select,
    input wire logic converter_clock,
    output logic result_ready_n
);

    logic pending_reg; // A fresh low is owed after a one-cycle high pulse.
    logic [1:0] tick_count_reg; // Converter clocks seen while low in standby.

    // Restart wins, then a new result, then read or standby return.
    always_ff @(posedge clk) begin
        if (reset) begin
            result_ready_n <= 1'b1;
            pending_reg <= 1'b0;
            tick_count_reg <= 2'h0;
        end else if (restart) begin
            result_ready_n <= 1'b1;
            pending_reg <= 1'b0;
            tick_count_reg <= 2'h0;
        end else if (result) begin
            tick_count_reg <= 2'h0;
            // Unread data: pulse high first so every result gets a falling edge.
            if (!result_ready_n) begin
                result_ready_n <= 1'b1;
                pending_reg <= 1'b1;
            end else begin
                result_ready_n <= 1'b0;
            end
        end else if (pending_reg) begin
            result_ready_n <= 1'b0;
            pending_reg <= 1'b0;
        end else if (read_hit) begin
            result_ready_n <= 1'b1;
        end else if (standby_select && !result_ready_n && converter_clock) begin
            // Third converter clock after the fall returns the level high.
            if (tick_count_reg == adc_serial_pkg::STANDBY_READY_TICKS - 2'h1) begin
                result_ready_n <= 1'b1;
                tick_count_reg <= 2'h0;
            end else begin
                tick_count_reg <= tick_count_reg + 2'h1;
            end
        end
    end

endmodule

// File: core/adc_serial_port.sv
`timescale 1ns/10ps

// Contract
// - Unipolar codes straight binary, clipped zero to full.
// - Ready high on start, low on new data.
// - Sync and start-stop: ready high at eighth bit.
// - One-shot mode keeps ready low during read.
// - Standby: ready high three converter clocks later.
// - Unread data: short high pulse before falling.
// - Dedicated ready output always driven.
// - Dual output mirrors ready until first rising.
// - Dual output reverts after final frame falling edge.
// - Header bit zero flags new unread data.
// - First conversion after start lasts filter latency.
// - Header enable prefixes status byte to data.
// - After own frame, pass input bits through.
// - Four-wire command interpreted only when chip select rises.
// - Chip select low at reset selects three-wire.
// - Three-wire frames delimited by counted serial clocks.
// - Sixty-three ones then zero resynchronises framing.
// - Data-only mode holds output until first clock.
// - Status bit seven: one three-wire, zero four-wire.
module adc_serial_port #(
    parameter int TIMER_BITS = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic converter_clock,
    input wire logic [1:0] control_mode,
    input wire logic start_pulse,
    input wire logic stop_pulse,
    input wire logic [TIMER_BITS-1:0] filter_latency,
    input wire logic [TIMER_BITS-1:0] conversion_period,
    input wire logic signed [17:0] raw_sample,
    input wire logic unipolar_mode,
    input wire logic extended_range,
    input wire logic standby_select,
    input wire logic dual_output_select,
    input wire logic header_enable,
    input wire logic crc_enable,
    input wire logic [7:0] crc_byte,
    input wire logic [5:0] status_flags,
    output logic result_ready_n,
    output logic dual_function_output,
    output logic dual_function_output_en,
    output logic three_wire,
    output logic [31:0] command_word,
    output logic command_valid,
    output logic [15:0] result_code
);

    // Widest frame in bits.
    localparam int MAX_BITS = adc_serial_pkg::MAX_FRAME_BITS;

    // Synchronised pin levels.
    logic sclk_s; // Filtered serial clock.
    logic cs_n_s; // Filtered chip select.
    logic sdi_s; // Filtered serial input.
    logic sclk_d_reg; // Serial clock one cycle back, for edge finding.
    logic cs_n_d_reg; // Chip select one cycle back.

    // Conversion timing state.
    logic running_reg; // Conversions are in progress.
    logic first_reg; // The current conversion is the first after a start.
    logic [TIMER_BITS-1:0] timer_reg; // Converter clocks into the conversion.
    logic new_data_reg; // Buffered result not yet read.
    logic [2:0] strap_count_reg; // Cycles since reset release.
    logic strap_done_reg; // Chip select strap has been caught.

    // Frame state.
    logic [5:0] bit_count_reg; // Falling edges seen in this frame.
    logic [6:0] ones_count_reg; // Consecutive ones on the serial input.
    logic [MAX_BITS-1:0] shift_reg; // Outgoing frame and incoming bits.
    logic in_frame_reg; // Between first rising edge and frame completion.
    logic data_mode_reg; // Dual pin currently shows serial data.
    logic sdo_bit_reg; // Serial data bit last driven.

    pin_sync #(.RESET_LEVEL(1'b0)) sclk_sync (
        .clk(clk),
        .reset(reset),
        .pin(sclk),
        .level(sclk_s)
    );

    pin_sync #(.RESET_LEVEL(1'b1)) cs_sync (
        .clk(clk),
        .reset(reset),
        .pin(cs_n),
        .level(cs_n_s)
    );

    pin_sync #(.RESET_LEVEL(1'b0)) sdi_sync (
        .clk(clk),
        .reset(reset),
        .pin(sdi),
        .level(sdi_s)
    );

    // Edge and control decoding.
    wire sclk_rise = sclk_s && !sclk_d_reg;
    wire sclk_fall = !sclk_s && sclk_d_reg;
    wire cs_rise = cs_n_s && !cs_n_d_reg;
    wire cs_fall = !cs_n_s && cs_n_d_reg;
    wire selected = three_wire || !cs_n_s;
    wire is_one_shot = control_mode == adc_serial_pkg::MODE_ONE_SHOT;

    // Frame length: 16 data bits plus optional header and check bytes.
    wire [5:0] header_len = header_enable ? adc_serial_pkg::EXTRA_BYTE_LEN : 6'h00;
    wire [5:0] crc_len = crc_enable ? adc_serial_pkg::EXTRA_BYTE_LEN : 6'h00;
    wire [5:0] frame_len = adc_serial_pkg::BASE_FRAME_LEN + header_len + crc_len;
    wire [5:0] last_bit = frame_len - 6'h01;
    // The read counts as taken at the eighth bit of the leading data byte.
    wire [5:0] read_point = header_len + adc_serial_pkg::EXTRA_BYTE_LEN;

    // Conversion timer: the first period is the filter latency.
    wire [TIMER_BITS-1:0] period_now = first_reg ? filter_latency : conversion_period;
    wire conv_done = running_reg && converter_clock
                     && (timer_reg >= period_now - TIMER_BITS'(1));
    wire restart = start_pulse;

    // Output code formatting. Extended range scales by 0.8 before clipping.
    wire signed [33:0] scaled_prod = raw_sample * $signed({1'b0, adc_serial_pkg::EXT_SCALE_MUL});
    wire signed [17:0] scaled_ext = 18'(scaled_prod >>> adc_serial_pkg::EXT_SCALE_SHIFT);
    wire signed [17:0] scaled = extended_range ? scaled_ext : raw_sample;
    wire [15:0] uni_code = (scaled <= 18'sh00000) ? adc_serial_pkg::UNI_ZERO
                         : (scaled >= adc_serial_pkg::UNI_MAX_RAW)
                         ? adc_serial_pkg::UNI_FULL_SCALE : scaled[15:0];
    wire [15:0] bip_code = (scaled >= adc_serial_pkg::BIP_MAX_RAW)
                         ? adc_serial_pkg::BIP_MAX_RAW[15:0]
                         : (scaled <= adc_serial_pkg::BIP_MIN_RAW)
                         ? adc_serial_pkg::BIP_MIN_RAW[15:0] : scaled[15:0];
    wire [15:0] next_code = unipolar_mode ? uni_code : bip_code;

    // Status header mirrors the status register with our own two bits.
    wire [7:0] status_byte = {three_wire, status_flags, new_data_reg};

    // Frame word right-aligned so bit frame_len-1 goes out first.
    wire [31:0] full_word = {status_byte, result_code, crc_byte};
    wire [31:0] no_head_word = {8'h00, result_code, crc_byte};
    wire [31:0] head_word = header_enable ? full_word : no_head_word;
    wire [31:0] frame_word = crc_enable ? head_word : (head_word >> 8);

    // Frame boundaries.
    wire frame_load = selected && sclk_rise && (bit_count_reg == 6'h00);
    wire bit_in = selected && sclk_fall;
    wire frame_full = bit_in && (bit_count_reg == last_bit);
    wire resync_hit = three_wire && bit_in && !sdi_s
                      && (ones_count_reg >= adc_serial_pkg::RESYNC_ONES);
    wire [31:0] shifted_in = {shift_reg[30:0], sdi_s};
    wire read_hit_now = bit_in && (bit_count_reg + 6'h01 == read_point)
                        && !is_one_shot;
    // Any read clears the new-data flag, one-shot mode too.
    wire read_taken = bit_in && (bit_count_reg + 6'h01 == read_point);

    // Ready stays driven, selected or not.
    ready_signal ready_gen (
        .clk(clk),
        .reset(reset),
        .restart(restart),
        .result(conv_done),
        .read_hit(read_hit_now),
        .standby_select(standby_select),
        .converter_clock(converter_clock),
        .result_ready_n(result_ready_n)
    );

    // Pin history for edge detection.
    always_ff @(posedge clk) begin
        if (reset) begin
            sclk_d_reg <= 1'b0;
            cs_n_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s;
            cs_n_d_reg <= cs_n_s;
        end
    end

    // Strap capture happens a few cycles after release, once the synchroniser
    // has filled; an asynchronous catch of a pin at reset would be unsafe.
    always_ff @(posedge clk) begin
        if (reset) begin
            strap_count_reg <= 3'h0;
            strap_done_reg <= 1'b0;
            three_wire <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_count_reg <= strap_count_reg + 3'h1;
            // One count past the flop depth lets the filtered level settle first.
            if (strap_count_reg == adc_serial_pkg::STRAP_WAIT_CYCLES) begin
                strap_done_reg <= 1'b1;
                three_wire <= !cs_n_s;
            end
        end else if (cs_n_s) begin
            three_wire <= 1'b0;
        end
    end

    // Conversion timer; a start pulse restarts from the filter latency.
    always_ff @(posedge clk) begin
        if (reset) begin
            running_reg <= 1'b0;
            first_reg <= 1'b1;
            timer_reg <= '0;
        end else if (restart) begin
            running_reg <= 1'b1;
            first_reg <= 1'b1;
            timer_reg <= '0;
        end else if (stop_pulse && control_mode == adc_serial_pkg::MODE_START_STOP) begin
            running_reg <= 1'b0;
        end else if (conv_done) begin
            timer_reg <= '0;
            first_reg <= 1'b0;
            // One-shot mode converts once and then idles.
            running_reg <= !is_one_shot;
        end else if (running_reg && converter_clock) begin
            timer_reg <= timer_reg + TIMER_BITS'(1);
        end
    end

    // Result buffer and new-data flag; a new result wins over a read clear.
    always_ff @(posedge clk) begin
        if (reset) begin
            result_code <= 16'h0000;
            new_data_reg <= 1'b0;
        end else if (conv_done) begin
            result_code <= next_code;
            new_data_reg <= 1'b1;
        end else if (restart) begin
            new_data_reg <= 1'b0;
        end else if (read_taken) begin
            new_data_reg <= 1'b0;
        end
    end

    // Bit counting, three-wire framing and pattern resync.
    always_ff @(posedge clk) begin
        if (reset) begin
            bit_count_reg <= 6'h00;
            ones_count_reg <= 7'h00;
        end else if (!three_wire && (cs_fall || cs_rise)) begin
            bit_count_reg <= 6'h00;
            ones_count_reg <= 7'h00;
        end else if (bit_in) begin
            // Saturating count of consecutive ones for the reset pattern.
            if (sdi_s) begin
                if (ones_count_reg != 7'h7f) begin
                    ones_count_reg <= ones_count_reg + 7'h01;
                end
            end else begin
                ones_count_reg <= 7'h00;
            end
            if (resync_hit) begin
                bit_count_reg <= 6'h00;
            end else if (three_wire && frame_full) begin
                bit_count_reg <= 6'h00;
            end else if (bit_count_reg != 6'h3f) begin
                bit_count_reg <= bit_count_reg + 6'h01;
            end
        end
    end

    // Shift path: the frame goes out, input bits follow it for chaining.
    always_ff @(posedge clk) begin
        if (reset) begin
            shift_reg <= '0;
            sdo_bit_reg <= 1'b0;
        end else if (frame_load) begin
            shift_reg <= frame_word;
            sdo_bit_reg <= frame_word[last_bit[4:0]];
        end else if (selected && sclk_rise) begin
            // Bits shifted in last frame_len edges ago now reach the pin.
            sdo_bit_reg <= shift_reg[last_bit[4:0]];
        end else if (bit_in) begin
            shift_reg <= shifted_in;
        end
    end

    // Dual pin mode: ready mirror outside reads, data from first rising edge.
    always_ff @(posedge clk) begin
        if (reset) begin
            in_frame_reg <= 1'b0;
            data_mode_reg <= 1'b0;
        end else if (!selected) begin
            in_frame_reg <= 1'b0;
            data_mode_reg <= 1'b0;
        end else if (frame_load) begin
            in_frame_reg <= 1'b1;
            data_mode_reg <= 1'b1;
        end else if (frame_full || resync_hit) begin
            // Frame done or resynced: back to the ready mirror.
            in_frame_reg <= 1'b0;
            data_mode_reg <= 1'b0;
        end
    end

    // Pin driver. In data-only mode the pin keeps its last bit between
    // frames, so chained devices see a stable level.
    always_ff @(posedge clk) begin
        if (reset) begin
            dual_function_output <= 1'b1;
            dual_function_output_en <= 1'b0;
        end else if (dual_output_select) begin
            dual_function_output_en <= selected;
            if (data_mode_reg || (in_frame_reg && !frame_full)) begin
                dual_function_output <= sdo_bit_reg;
            end else begin
                dual_function_output <= result_ready_n;
            end
        end else begin
            dual_function_output_en <= selected;
            dual_function_output <= sdo_bit_reg;
        end
    end

    // Command hand-off: four-wire on chip select rise, three-wire on count.
    always_ff @(posedge clk) begin
        if (reset) begin
            command_word <= 32'h00000000;
            command_valid <= 1'b0;
        end else if (!three_wire && cs_rise && bit_count_reg != 6'h00) begin
            // A select with no clocks carries no command.
            command_word <= shift_reg;
            command_valid <= 1'b1;
        end else if (three_wire && frame_full && !resync_hit) begin
            command_word <= shifted_in;
            command_valid <= 1'b1;
        end else begin
            command_valid <= 1'b0;
        end
    end

endmodule

// File: test/adc_serial_port_properties.sv
`timescale 1ns/10ps

// Watches the ready line, frame end and wire mode of the serial port.
module adc_serial_port_properties #(
    parameter int TIMER_BITS = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [1:0] control_mode,
    input wire logic start_pulse,
    input wire logic standby_select,
    input wire logic dual_output_select,
    input wire logic result_ready_n,
    input wire logic dual_function_output,
    input wire logic dual_function_output_en,
    input wire logic three_wire,
    input wire logic command_valid
);
    // Cycles since the clock pin was last high; a long run means no bit is in flight.
    logic [5:0] idle_cnt_reg;

    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);

    // The count saturates so a long idle never wraps back into a frame window.
    always_ff @(posedge clk) begin
        if (reset || sclk) begin
            idle_cnt_reg <= 6'h00;
        end else if (idle_cnt_reg != 6'h3f) begin
            idle_cnt_reg <= idle_cnt_reg + 6'h01;
        end
    end

    sequence s_low_hold;
        !result_ready_n [*3];
    endsequence
    sequence s_back_high;
        ##[1:14] result_ready_n;
    endsequence

    property p_start_high;
        start_pulse |-> ##[1:2] result_ready_n;
    endproperty
    a_start_high: assert property (p_start_high)
        else $error("ready not high after start");
    property p_one_shot_low;
        control_mode == adc_serial_pkg::MODE_ONE_SHOT && !standby_select && !result_ready_n
            && !start_pulse && !$past(start_pulse) |=> !result_ready_n;
    endproperty
    a_one_shot_low: assert property (p_one_shot_low)
        else $error("ready left low level in one-shot mode");
    property p_standby;
        standby_select && $fell(result_ready_n) |-> s_low_hold ##0 s_back_high;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby ready return out of window");
    property p_mirror;
        dual_output_select && !cs_n && !$past(cs_n, 8) && idle_cnt_reg > 6'h1c
            && $stable(result_ready_n) && result_ready_n == $past(result_ready_n, 2)
            |-> dual_function_output == result_ready_n;
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("dual pin not mirroring ready");
    property p_cs_end;
        command_valid && !three_wire |-> cs_n;
    endproperty
    a_cs_end: assert property (p_cs_end)
        else $error("command taken before select release");
    property p_valid_pulse;
        command_valid |=> !command_valid;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("command strobe longer than one cycle");
    property p_four_wire;
        cs_n [*8] |=> !three_wire;
    endproperty
    a_four_wire: assert property (p_four_wire)
        else $error("three-wire mode kept with select high");
    property p_three_en;
        three_wire && $past(three_wire) |-> dual_function_output_en;
    endproperty
    a_three_en: assert property (p_three_en)
        else $error("output not driven in three-wire mode");
endmodule

bind adc_serial_port adc_serial_port_properties #(.TIMER_BITS(TIMER_BITS)) chk (
    .clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .control_mode(control_mode),
    .start_pulse(start_pulse), .standby_select(standby_select),
    .dual_output_select(dual_output_select), .result_ready_n(result_ready_n),
    .dual_function_output(dual_function_output),
    .dual_function_output_en(dual_function_output_en), .three_wire(three_wire),
    .command_valid(command_valid));

// File: test/spi_host_model.sv
`timescale 1ns/10ps

// Host controller: clocks frames MSB first and collects the returned bits.
module spi_host_model (
    input wire logic sdo,
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    // Clock idles low; it stands still between frames.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    task automatic set_cs(input logic lvl);
        cs_n = lvl;
    endtask

    // With keep_low the select stays low, so the bit count alone frames it.
    task automatic xfer(input int n, input logic [63:0] tx, input logic keep_low,
            output logic [63:0] rx);
        rx = 64'h0;
        cs_n = 1'b0;
        #80;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b1;
            sdi = tx[i];
            #40;
            sclk = 1'b0;
            rx = {rx[62:0], sdo};
            #40;
        end
        // A released data line flips so a stale bit never passes as valid.
        sdi = ~sdi;
        #80;
        if (!keep_low) begin
            cs_n = 1'b1;
        end
        #80;
    endtask
endmodule

// File: test/adc_serial_port_bench.sv
`timescale 1ns/10ps

// Drives conversions and host frames into the serial port and checks the results.
module adc_serial_port_bench;
    logic clk, reset, sclk, cs_n, sdi, converter_clock, start_pulse;
    logic [1:0] control_mode;
    logic signed [17:0] raw_sample;
    logic unipolar_mode, extended_range, standby_select, dual_output_select, header_enable;
    logic [5:0] status_flags;
    logic result_ready_n, dfo, dfo_en, three_wire, command_valid;
    logic [31:0] command_word;
    logic [15:0] result_code;
    logic [1:0] tick_reg = 2'h0;
    logic [63:0] rx;
    int failures = 0;
    int cmp_count = 0;
    int hi;
    // Code table: raw value, range, polarity and the expected output code.
    logic signed [17:0] raw_tab [5] = '{18'sh10000, 18'sh00001, -18'sh00005, 18'sh10000,
        -18'sh08000};
    logic [4:0] ext_bits = 5'h08;
    logic [4:0] uni_bits = 5'h0f;
    logic [15:0] exp_tab [5] = '{16'hffff, 16'h0001, 16'h0000, 16'hcccc, 16'h8000};
    // The pin is taken to have a pull-up when the converter does not drive it.
    wire sdo_wire = dfo_en ? dfo : 1'b1;

    adc_serial_port uut (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .converter_clock(converter_clock), .control_mode(control_mode),
        .start_pulse(start_pulse), .stop_pulse(1'b0), .filter_latency(16'h001e),
        .conversion_period(16'h01f4), .raw_sample(raw_sample), .unipolar_mode(unipolar_mode),
        .extended_range(extended_range), .standby_select(standby_select),
        .dual_output_select(dual_output_select), .header_enable(header_enable),
        .crc_enable(1'b0), .crc_byte(8'h00), .status_flags(status_flags),
        .result_ready_n(result_ready_n), .dual_function_output(dfo),
        .dual_function_output_en(dfo_en), .three_wire(three_wire),
        .command_word(command_word), .command_valid(command_valid),
        .result_code(result_code));
    spi_host_model host (.sdo(sdo_wire), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Converter clock tick every fourth cycle.
    always @(negedge clk) begin
        tick_reg <= tick_reg + 2'h1;
        converter_clock <= (tick_reg == 2'h3);
    end

    task automatic stop_test;
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask

    // The select level at reset release picks the wire mode.
    task automatic do_reset(input logic cs_lvl);
        @(negedge clk);
        host.set_cs(cs_lvl);
        reset = 1'b1;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        repeat (8) @(negedge clk);
    endtask

    task automatic pulse_start;
        @(negedge clk);
        start_pulse = 1'b1;
        @(negedge clk);
        start_pulse = 1'b0;
    endtask

    // Waits for a ready high then low; hi returns how many cycles it stood high.
    task automatic wait_ready(output int hi);
        int n;
        hi = 0;
        for (n = 0; n < 4000 && !(hi > 0 && result_ready_n === 1'b0); n++) begin
            @(negedge clk);
            if (result_ready_n === 1'b1) begin
                hi++;
            end
        end
        if (n == 4000) begin
            failures++;
            $display("[ERR] %0t ready never fell", $time);
            stop_test();
        end
    endtask

    initial begin
        reset = 1'b1;
        start_pulse = 1'b0;
        control_mode = 2'h0;
        raw_sample = 18'sh00000;
        {unipolar_mode, extended_range, standby_select} = 3'h4;
        {dual_output_select, header_enable} = 2'h0;
        status_flags = 6'h2a;
        do_reset(1'b1);
        chk1(result_ready_n, 1'b1);
        chk1(three_wire, 1'b0);
        pulse_start();
        for (int i = 0; i < 5; i++) begin
            raw_sample = raw_tab[i];
            extended_range = ext_bits[i];
            unipolar_mode = uni_bits[i];
            wait_ready(hi);
            chk16(result_code, exp_tab[i]);
            if (i > 0) begin
                chk16(hi[15:0], 16'h0001);
            end
        end
        {unipolar_mode, extended_range, dual_output_select} = 3'h5;
        raw_sample = 18'sh0a5c3;
        wait_ready(hi);
        host.xfer(16, 64'h1234, 1'b0, rx);
        chk16(rx[15:0], 16'ha5c3);
        chk1(result_ready_n, 1'b1);
        chk16(command_word[15:0], 16'h1234);
        header_enable = 1'b1;
        wait_ready(hi);
        host.xfer(24, 64'h0, 1'b0, rx);
        chk1(rx[16], 1'b1);
        chk1(rx[23], 1'b0);
        chk16({10'h000, rx[22:17]}, {10'h000, status_flags});
        host.xfer(24, 64'h0, 1'b0, rx);
        chk1(rx[16], 1'b0);
        {header_enable, dual_output_select} = 2'h0;
        wait_ready(hi);
        host.xfer(32, 64'hbeef5a5a, 1'b0, rx);
        chk16(rx[15:0], 16'hbeef);
        chk16(rx[31:16], 16'ha5c3);
        chk16(command_word[15:0], 16'h5a5a);
        do_reset(1'b1);
        control_mode = 2'h2;
        pulse_start();
        wait_ready(hi);
        host.xfer(16, 64'h0, 1'b0, rx);
        chk1(result_ready_n, 1'b0);
        do_reset(1'b1);
        control_mode = 2'h1;
        standby_select = 1'b1;
        pulse_start();
        wait_ready(hi);
        repeat (20) @(negedge clk);
        chk1(result_ready_n, 1'b1);
        standby_select = 1'b0;
        do_reset(1'b0);
        chk1(three_wire, 1'b1);
        host.xfer(16, 64'h00c3, 1'b1, rx);
        chk16(command_word[15:0], 16'h00c3);
        host.xfer(5, 64'h15, 1'b1, rx);
        host.xfer(64, 64'hffff_ffff_ffff_fffe, 1'b1, rx);
        host.xfer(16, 64'h0f0f, 1'b1, rx);
        chk16(command_word[15:0], 16'h0f0f);
        host.xfer(0, 64'h0, 1'b0, rx);
        chk1(three_wire, 1'b0);
        chk16(command_word[15:0], 16'h0f0f);
        stop_test();
    end
endmodule
